// ---- logic/exec_pkg.sv ----
// package for the call stack and alu execution block
// assumes a single core clock; opcodes are decoded upstream into an op code
package exec_pkg;

   // =========================================================
   // widths
   localparam int PC_W   = 6;
   localparam int BANK_W = 3;
   localparam int DAT_W  = 4;
   localparam int FILE_W = 2;
   localparam int DEPTH  = 3;

   // =========================================================
   // reset values
   localparam logic [5:0] PC_RST   = 6'h00;
   localparam logic [2:0] BANK_RST = 3'h0;
   localparam logic [3:0] DAT_RST  = 4'h0;
   localparam logic       FLAG_RST = 1'b1;

   // =========================================================
   // arithmetic constants
   localparam logic [3:0] ONE_4   = 4'h1;
   localparam logic [3:0] MINUS_1 = 4'hF;
   localparam logic [3:0] MAX_4   = 4'hF;

   // =========================================================
   // operations
   typedef enum logic [3:0] {
      OP_NONE   = 4'h0,
      OP_CALL   = 4'h1,
      OP_EXIT   = 4'h2,
      OP_LDBANK = 4'h3,
      OP_ADDW   = 4'h4,
      OP_SUBW   = 4'h5,
      OP_INCW   = 4'h6,
      OP_DECW   = 4'h7,
      OP_INCA   = 4'h8,
      OP_INCY   = 4'h9,
      OP_DECA   = 4'hA,
      OP_DECY   = 4'hB,
      OP_XORW   = 4'hC,
      OP_TWOS_COMPLEMENT_ACC   = 4'hD,
      OP_LEW    = 4'hE,
      OP_LEI    = 4'hF
   } op_t;

   // nonzero test shares no code room; flagged by a separate strobe

   // 4-bit add giving carry in bit 4
   function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b);
      add5 = {1'b0, a} + {1'b0, b};
   endfunction : add5

endpackage : exec_pkg

// ---- logic/pc_step.sv ----
// next address of the program counter along the pseudo-random sequence
// assumes a 6-bit counter stepped as a linear feedback shift register
`timescale 1ns/100ps
module pc_step
   import exec_pkg::*;
(
   // current and next address
   input  wire logic [PC_W-1:0] cur,
   output wire logic [PC_W-1:0] nxt
);

   // shift left, feed back xnor of top two bits, so all-zero is legal
   wire logic fb;
   assign fb  = ~(cur[5] ^ cur[4]);
   assign nxt = {cur[4:0], fb};

endmodule : pc_step

// ---- logic/stack3.sv ----
// three level return stack: return address and bank side by side
// assumes push and pop are never asserted together
`timescale 1ns/100ps
module stack3
   import exec_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // control
   input  wire logic              push,
   input  wire logic              pop,
   input  wire logic [PC_W-1:0]   pushAddr,
   input  wire logic [BANK_W-1:0] pushBank,
   // top level
   output wire logic [PC_W-1:0]   topAddr,
   output wire logic [BANK_W-1:0] topBank
);

   logic [PC_W-1:0]   addrLvl [DEPTH];
   logic [BANK_W-1:0] bankLvl [DEPTH];

   assign topAddr = addrLvl[0];
   assign topBank = bankLvl[0];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            addrLvl[i] <= PC_RST;
            bankLvl[i] <= BANK_RST;
         end
      end else if (push) begin
         // oldest level falls off the bottom
         addrLvl[0] <= pushAddr; // [RQ3]
         bankLvl[0] <= pushBank;
         for (int i = 1; i < DEPTH; i++) begin
            addrLvl[i] <= addrLvl[i-1];
            bankLvl[i] <= bankLvl[i-1];
         end
      end else if (pop) begin
         // bottom address level keeps its value on a pop
         for (int i = 0; i < DEPTH-1; i++) begin
            addrLvl[i] <= addrLvl[i+1]; // [RQ5]
            bankLvl[i] <= bankLvl[i+1];
         end
      end
   end

endmodule : stack3

// ---- logic/call_stack_and_alu_ops.sv ----
// execution of call, return, bank load and 4-bit alu operations
// assumes an upstream decoder presents one op per cycle with opValid;
// the RAM word at the file/word pointer is returned combinationally.
//
// Notes on behaviour
// [RQ1] flag 1: call jumps, bank takes buffer, pushes next address and bank
// [RQ2] flag 0: call steps on, buffer reloads from bank, flag forced to 1
// [RQ3] both stacks hold three levels; push discards level three
// [RQ4] call without prior buffer load stays in the current bank
// [RQ5] return pops address and bank into counter, bank, buffer; flag set
// [RQ6] bank buffer load stores three low bits of operand only
// [RQ7] counter steps along a pseudo-random sequence, also for return addresses
// [RQ8] add word: 4-bit sum to acc, flag is carry
// [RQ9] subtract: word minus acc to acc, flag set when no borrow
// [RQ10] increment word into acc, flag is carry
// [RQ11] decrement word into acc, flag set when word nonzero
// [RQ12] increment acc, flag forced to 1
// [RQ13] increment word pointer, flag set when it was 15
// [RQ14] decrement acc, flag cleared on borrow
// [RQ15] decrement word pointer, flag cleared on borrow
// [RQ16] xor word into acc, flag set
// [RQ17] negate acc, flag set when acc zero
// [RQ18] compare acc <= word, nothing but flag changes
// [RQ19] compare acc <= constant, acc unchanged
// [RQ20] word nonzero test sets flag only
// [RQ21] RAM word selected by file pointer 0..3 and word pointer
// [RQ22] results wrap modulo 16; carry only reaches the flag
`timescale 1ns/100ps
module call_stack_and_alu_ops
   import exec_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // decoded instruction
   input  wire logic              opValid,
   input  wire op_t               opCode,
   input  wire logic              nonzeroTest,
   input  wire logic [PC_W-1:0]   operandAddr,
   input  wire logic [DAT_W-1:0]  operandConst,
   // RAM word access
   input  wire logic [DAT_W-1:0]  ramWord,
   output logic      [FILE_W-1:0] ramFile,
   output logic      [DAT_W-1:0]  ramIndex,
   // pointer preload from the data move path
   input  wire logic              filePtrLoad,
   input  wire logic [FILE_W-1:0] filePtrValue,
   // architectural state
   output logic      [PC_W-1:0]   program_counter,
   output logic      [BANK_W-1:0] current_rom_bank,
   output logic      [BANK_W-1:0] bank_buffer,
   output logic      [DAT_W-1:0]  acc,
   output logic                   condition_flag
);

   // =========================================================
   // stack and counter step
   logic [PC_W-1:0]   pcNext;
   logic [PC_W-1:0]   stackAddr;
   logic [BANK_W-1:0] stackBank;
   wire  logic        doCall;
   wire  logic        doExit;
   wire  logic        taken;

   pc_step u_step (
      .cur (program_counter),
      .nxt (pcNext)
   );

   assign taken  = condition_flag;
   assign doCall = opValid && !nonzeroTest && (opCode == OP_CALL) && taken;
   assign doExit = opValid && !nonzeroTest && (opCode == OP_EXIT);

   stack3 u_stack (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .push     (doCall), // [RQ3]
      .pop      (doExit),
      .pushAddr (pcNext),
      .pushBank (current_rom_bank),
      .topAddr  (stackAddr),
      .topBank  (stackBank)
   );

   // =========================================================
   // alu
   wire logic [4:0] sumAdd;
   wire logic [4:0] sumSub;
   wire logic [4:0] sumIncW;
   wire logic [4:0] sumDecW;
   wire logic [4:0] sumIncA;
   wire logic [4:0] sumDecA;
   wire logic [4:0] sumIncY;
   wire logic [4:0] sumDecY;
   wire logic [4:0] sumLeI;
   wire logic [4:0] sumNeg;

   // subtraction by two's-complement addition, carry means no borrow
   assign sumAdd  = add5(ramWord, acc); // [RQ8]
   assign sumSub  = add5(ramWord, ~acc) + 5'h01; // [RQ9]
   assign sumIncW = add5(ramWord, ONE_4); // [RQ10]
   assign sumDecW = add5(ramWord, MINUS_1); // [RQ11]
   assign sumIncA = add5(acc, ONE_4); // [RQ12]
   assign sumDecA = add5(acc, MINUS_1); // [RQ14]
   assign sumIncY = add5(ramIndex, ONE_4); // [RQ13]
   assign sumDecY = add5(ramIndex, MINUS_1); // [RQ15]
   assign sumLeI  = add5(operandConst, ~acc) + 5'h01; // [RQ19]
   assign sumNeg  = add5(~acc, ONE_4); // [RQ17]

   // =========================================================
   // next-state selection
   logic [DAT_W-1:0]  next_acc;
   logic [DAT_W-1:0]  next_index;
   logic              next_flag;
   logic [PC_W-1:0]   next_pc;
   logic [BANK_W-1:0] next_bank;
   logic [BANK_W-1:0] next_buf;

   always_comb begin
      next_acc   = acc;
      next_index = ramIndex;
      next_flag  = condition_flag;
      next_pc    = pcNext; // [RQ7]
      next_bank  = current_rom_bank;
      next_buf   = bank_buffer;
      if (nonzeroTest) begin
         next_flag = (ramWord != DAT_RST); // [RQ20]
      end else begin
         case (opCode)
            OP_CALL: begin
               if (taken) begin
                  next_pc   = operandAddr; // [RQ1]
                  // equal buffer and bank keeps the call local
                  next_bank = bank_buffer; // [RQ4]
               end else begin
                  next_buf  = current_rom_bank; // [RQ2]
                  next_flag = 1'b1;
               end
            end
            OP_EXIT: begin
               next_pc   = stackAddr; // [RQ5]
               next_bank = stackBank;
               next_buf  = stackBank;
               next_flag = 1'b1;
            end
            OP_LDBANK: begin
               next_buf  = operandConst[BANK_W-1:0]; // [RQ6]
               next_flag = 1'b1;
            end
            OP_ADDW: begin
               next_acc  = sumAdd[3:0]; // [RQ22]
               next_flag = sumAdd[4];
            end
            OP_SUBW: begin
               next_acc  = sumSub[3:0];
               next_flag = sumSub[4];
            end
            OP_INCW: begin
               next_acc  = sumIncW[3:0];
               next_flag = sumIncW[4];
            end
            OP_DECW: begin
               next_acc  = sumDecW[3:0];
               next_flag = sumDecW[4];
            end
            OP_INCA: begin
               // carry is dropped on purpose
               next_acc  = sumIncA[3:0];
               next_flag = 1'b1;
            end
            OP_INCY: begin
               next_index = sumIncY[3:0];
               next_flag  = sumIncY[4];
            end
            OP_DECA: begin
               next_acc  = sumDecA[3:0];
               next_flag = sumDecA[4];
            end
            OP_DECY: begin
               next_index = sumDecY[3:0];
               next_flag  = sumDecY[4];
            end
            OP_XORW: begin
               next_acc  = ramWord ^ acc; // [RQ16]
               next_flag = 1'b1;
            end
            OP_TWOS_COMPLEMENT_ACC: begin
               next_acc  = sumNeg[3:0];
               next_flag = sumNeg[4];
            end
            OP_LEW: begin
               next_flag = sumSub[4]; // [RQ18]
            end
            OP_LEI: begin
               next_flag = sumLeI[4];
            end
            default: begin
               next_flag = condition_flag;
            end
         endcase
      end
   end

   // =========================================================
   // state registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         program_counter  <= PC_RST;
         current_rom_bank <= BANK_RST;
         bank_buffer      <= BANK_RST;
         acc              <= DAT_RST;
         ramIndex         <= DAT_RST;
         condition_flag   <= FLAG_RST;
      end else if (opValid) begin
         program_counter  <= next_pc;
         current_rom_bank <= next_bank;
         bank_buffer      <= next_buf;
         acc              <= next_acc;
         ramIndex         <= next_index;
         condition_flag   <= next_flag;
      end
   end

   // file pointer selects one of four RAM pages
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ramFile <= 2'h0;
      end else if (filePtrLoad) begin
         ramFile <= filePtrValue; // [RQ21]
      end
   end

endmodule : call_stack_and_alu_ops

// ---- test/exec_asserts.sv ----
// assertions on the ports of the execution block
// assumes it is bound to call_stack_and_alu_ops with one clock
`timescale 1ns/100ps
module exec_chk
   import exec_pkg::*;
(
   // clock and reset
   input wire logic              mclk,
   input wire logic              sys_rst,
   // instruction
   input wire logic              opValid,
   input wire op_t               opCode,
   input wire logic              nonzeroTest,
   input wire logic [PC_W-1:0]   operandAddr,
   input wire logic [DAT_W-1:0]  operandConst,
   input wire logic [DAT_W-1:0]  ramWord,
   // state
   input wire logic [PC_W-1:0]   program_counter,
   input wire logic [BANK_W-1:0] current_rom_bank,
   input wire logic [BANK_W-1:0] bank_buffer,
   input wire logic [DAT_W-1:0]  acc,
   input wire logic              condition_flag
);
   wire logic       go = opValid && !nonzeroTest;
   wire logic [4:0] sum = {1'b0, ramWord} + {1'b0, acc};
   wire logic [5:0] stepPc = {program_counter[4:0], ~(program_counter[5] ^ program_counter[4])};
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // properties
   call_jump_a: assert property (go && opCode == OP_CALL && condition_flag |=>
      program_counter == $past(operandAddr) && current_rom_bank == $past(bank_buffer))
      else $error("taken call wrong");
   call_skip_a: assert property (go && opCode == OP_CALL && !condition_flag |=>
      condition_flag && bank_buffer == $past(current_rom_bank)
      && program_counter == $past(stepPc)) else $error("skipped call wrong");
   exit_banks_a: assert property (go && opCode == OP_EXIT |=>
      bank_buffer == current_rom_bank && condition_flag) else $error("return wrong");
   bank_load_a: assert property (go && opCode == OP_LDBANK |=>
      bank_buffer == $past(operandConst[2:0]) && $stable(current_rom_bank))
      else $error("bank load wrong");
   add_carry_a: assert property (go && opCode == OP_ADDW |=>
      {condition_flag, acc} == $past(sum)) else $error("add wrong");
   inc_acc_a: assert property (go && opCode == OP_INCA |=>
      acc == $past(acc) + 4'h1 && condition_flag) else $error("acc increment wrong");
   le_const_a: assert property (go && opCode == OP_LEI |=>
      condition_flag == ($past(acc) <= $past(operandConst)) && $stable(acc))
      else $error("constant compare wrong");
   nonzero_test_a: assert property (opValid && nonzeroTest |=>
      condition_flag == ($past(ramWord) != 4'h0) && $stable(acc)
      && program_counter == $past(stepPc)) else $error("nonzero test wrong");
   cover property (go && opCode == OP_CALL && condition_flag);
   cover property (go && opCode == OP_EXIT);
   cover property (go && opCode == OP_ADDW && sum[4]);
endmodule : exec_chk

bind call_stack_and_alu_ops exec_chk i_chk (.mclk(mclk), .sys_rst(sys_rst),
   .opValid(opValid), .opCode(opCode), .nonzeroTest(nonzeroTest),
   .operandAddr(operandAddr), .operandConst(operandConst), .ramWord(ramWord),
   .program_counter(program_counter), .current_rom_bank(current_rom_bank),
   .bank_buffer(bank_buffer), .acc(acc), .condition_flag(condition_flag));

// ---- test/call_stack_and_alu_ops_tb.sv ----
// self-checking bench for the execution block
// assumes ramWord comes combinationally from the bench's own memory
`timescale 1ns/100ps
module call_stack_and_alu_ops_tb;
   import exec_pkg::*;
   logic        mclk, sys_rst, opValid, nonzeroTest, filePtrLoad, f, condition_flag;
   op_t         opCode;
   logic [5:0]  operandAddr, pc, s1, s2, s3, program_counter;
   logic [3:0]  operandConst, ramWord, a, y, ramIndex, acc;
   logic [2:0]  bk, bf, b1, b2, b3, current_rom_bank, bank_buffer;
   logic [1:0]  filePtrValue, x, ramFile;
   logic [3:0]  mem [0:63];
   logic [22:0] expQ [$];
   logic [22:0] e;
   int          n_fail, n_compared, cyc, seed, i;
   assign ramWord = mem[{ramFile, ramIndex}];
   call_stack_and_alu_ops i_dut (.mclk(mclk), .sys_rst(sys_rst), .opValid(opValid),
      .opCode(opCode), .nonzeroTest(nonzeroTest), .operandAddr(operandAddr),
      .operandConst(operandConst), .ramWord(ramWord), .ramFile(ramFile), .ramIndex(ramIndex),
      .filePtrLoad(filePtrLoad), .filePtrValue(filePtrValue),
      .program_counter(program_counter), .current_rom_bank(current_rom_bank),
      .bank_buffer(bank_buffer), .acc(acc), .condition_flag(condition_flag));
   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   task automatic check(input string nm, input logic [5:0] seen, input logic [5:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // ==========================================================
   // driver with reference model
   task automatic op(input op_t c, input logic [3:0] k, input logic [5:0] ad, input logic nz);
      logic [3:0] w;
      logic [5:0] np;
      w = mem[{x, y}];
      np = {pc[4:0], ~(pc[5] ^ pc[4])};
      opValid = 1;
      opCode = c;
      nonzeroTest = nz;
      operandConst = k;
      operandAddr = ad;
      filePtrLoad = 0;
      if (nz) f = w != 4'h0;
      else case (c)
         OP_CALL: if (f) begin
            {s3, s2, s1, b3, b2, b1} = {s2, s1, np, b2, b1, bk};
            {np, bk} = {ad, bf};
         end else {bf, f} = {bk, 1'b1};
         OP_EXIT: {np, bk, bf, s1, s2, b1, b2, f} = {s1, b1, b1, s2, s3, b2, b3, 1'b1};
         OP_LDBANK: {bf, f} = {k[2:0], 1'b1};
         OP_ADDW: {f, a} = {1'b0, w} + {1'b0, a};
         OP_SUBW: {f, a} = {a <= w, w - a};
         OP_INCW: {f, a} = {w == 4'hF, w + 4'h1};
         OP_DECW: {f, a} = {w != 4'h0, w - 4'h1};
         OP_INCA: {f, a} = {1'b1, a + 4'h1};
         OP_INCY: {f, y} = {y == 4'hF, y + 4'h1};
         OP_DECA: {f, a} = {a != 4'h0, a - 4'h1};
         OP_DECY: {f, y} = {y != 4'h0, y - 4'h1};
         OP_XORW: {f, a} = {1'b1, a ^ w};
         OP_TWOS_COMPLEMENT_ACC: {f, a} = {a == 4'h0, -a};
         OP_LEW: f = a <= w;
         OP_LEI: f = a <= k;
         default: ;
      endcase
      pc = np;
      expQ.push_back({pc, bk, bf, a, f, x, y});
      @(posedge mclk);
      #1;
   endtask : op
   task automatic fload(input logic [1:0] v);
      opValid = 0;
      filePtrLoad = 1;
      filePtrValue = v;
      x = v;
      expQ.push_back({pc, bk, bf, a, f, x, y});
      @(posedge mclk);
      #1;
   endtask : fload
   // ==========================================================
   // monitor and timeout
   always begin
      @(posedge mclk);
      if (!sys_rst && (opValid || filePtrLoad)) begin
         #2;
         e = expQ.pop_front();
         check("pc", program_counter, e[22:17]);
         check("bank", 6'(current_rom_bank), 6'(e[16:14]));
         check("buffer", 6'(bank_buffer), 6'(e[13:11]));
         check("acc", 6'(acc), 6'(e[10:7]));
         check("flag", 6'(condition_flag), 6'(e[6]));
         check("file", 6'(ramFile), 6'(e[5:4]));
         check("index", 6'(ramIndex), 6'(e[3:0]));
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         complete_run;
      end
   end
   // ==========================================================
   // tests
   initial begin
      seed = 32'he470;
      {sys_rst, opValid, nonzeroTest, filePtrLoad, filePtrValue} = 6'h20;
      opCode = OP_NONE;
      {operandAddr, operandConst} = '0;
      {pc, bk, bf, a, f, x, y} = 23'h0000_40;
      {s1, s2, s3, b1, b2, b3} = '0;
      for (i = 0; i < 64; i++) mem[i] = 4'($random(seed));
      repeat (3) @(posedge mclk);
      #1;
      sys_rst = 0;
      op(OP_DECA, 4'h0, 6'h00, 0);
      op(OP_CALL, 4'h0, 6'h2A, 0);
      for (i = 0; i < 4; i++) begin
         op(OP_LDBANK, 4'(i + 9), 6'h00, 0);
         op(OP_CALL, 4'h0, 6'(i * 7 + 3), 0);
      end
      op(OP_CALL, 4'h0, 6'h11, 0);
      repeat (6) op(OP_EXIT, 4'h0, 6'h00, 0);
      $display("test calls done");
      for (i = 0; i < 4; i++) begin
         fload(2'(3 - i));
         op(OP_NONE, 4'h0, 6'h00, 1);
         op(OP_ADDW, 4'h0, 6'h00, 0);
      end
      $display("test files done");
      for (i = 0; i < 400; i++) begin
         if (i % 50 == 7) fload(2'($random(seed)));
         mem[6'($random(seed))] = 4'($random(seed));
         op(op_t'(4'($random(seed))), 4'($random(seed)), 6'($random(seed)),
            3'($random(seed)) == 3'h0);
      end
      opValid = 0;
      filePtrLoad = 0;
      repeat (3) @(posedge mclk);
      check("queue", 6'(expQ.size()), 6'h00);
      $display("test random done");
      complete_run;
   end
endmodule : call_stack_and_alu_ops_tb
